// >>> rra_access_map.sv
// Two-wire bus slave, register file and clock output of the RTC access core.
`timescale 1ns/1ps
module rra_access_map #(
	parameter logic [6:0] DEV_ADDR = rra_pkg::DEF_DEV_ADDR
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Two-wire bus; data is open drain.
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe,
	// Oscillator and clock output.
	input wire logic osc_i,
	input wire logic clk_out_enable_in,
	output logic prog_freq_out
);
	typedef struct packed {
		rra_pkg::rra_bus_st_t st;
		logic [3:0] bits;
		logic [7:0] shift;
		logic [7:0] ptr;
		logic rw;
		logic busy;
		logic sclQ;
		logic sdaQ;
		logic sdaOe;
		logic freqOut;
		logic wrStb;
		logic [7:0] wrAddr;
		logic [7:0] wrData;
		logic [rra_pkg::REG_COUNT-1:0][7:0] regs;
	} rra_core_t;

	rra_core_t core_q;
	rra_core_t core_d;
	rra_pkg::rra_taps_t taps;
	rra_pkg::rra_time_t timeNow;
	rra_pkg::rra_wr_t timeWr;
	logic secTick;
	logic sclRise;
	logic sclFall;
	logic busStart;
	logic busStop;

	// Parameters the bus engine cannot serve.
	if (DEV_ADDR[6:3] == 4'h0 || DEV_ADDR[6:3] == 4'hf) begin : g_bad_addr
		$error("Device address lies in a reserved group.");
	end
	if (rra_pkg::CLK_HZ < rra_pkg::OVERSAMPLE_MIN * rra_pkg::BUS_MAX_BPS) begin : g_slow_clk
		$error("System clock too slow to sample the bus.");
	end

	function automatic logic [7:0] nextPtr(input logic [7:0] p);
		return (p >= rra_pkg::ADDR_LAST) ? rra_pkg::ADDR_FIRST : p + 8'h01;
	endfunction : nextPtr

	function automatic logic isTime(input logic [7:0] p);
		return (p >= rra_pkg::ADDR_SEC) && (p <= rra_pkg::ADDR_YEAR);
	endfunction : isTime

	// byte-wide map
	// Unmapped pointers read as zero so a runaway read stays harmless.
	function automatic logic [7:0] byteAt(input logic [7:0] p, input rra_core_t s, input rra_pkg::rra_time_t t);
		if (isTime(p)) begin
			return t[(rra_pkg::ADDR_YEAR - p) * 8 +: 8];
		end
		if (p <= rra_pkg::ADDR_LAST) begin
			return s.regs[p[4:0]];
		end
		return rra_pkg::REG_RESET;
	endfunction : byteAt

	function automatic logic tapSel(input logic [2:0] sel, input rra_pkg::rra_taps_t tp);
		if (sel == rra_pkg::FSEL_32K) begin
			return tp.osc;
		end
		if (sel <= rra_pkg::FSEL_1K) begin
			return tp.cnt[sel - 3'h1];
		end
		if (sel == rra_pkg::FSEL_1HZ) begin
			return tp.cnt[rra_pkg::DIV_BITS-1];
		end
		return 1'b0;
	endfunction : tapSel

	// Fetch the byte at the pointer and put its top bit on the wire.
	function automatic rra_core_t loadRead(input rra_core_t s, input rra_pkg::rra_time_t t);
		rra_core_t n;
		logic [7:0] b;
		n = s;
		b = byteAt(s.ptr, s, t);
		n.shift = b;
		n.sdaOe = ~b[7];
		n.bits = 4'h0;
		n.ptr = nextPtr(s.ptr);
		n.st = rra_pkg::ST_RDATA;
		return n;
	endfunction : loadRead

	// Bus conditions seen on the sampled lines.
	assign sclRise = scl_i && !core_q.sclQ;
	assign sclFall = !scl_i && core_q.sclQ;
	assign busStart = scl_i && core_q.sclQ && core_q.sdaQ && !sda_i;
	assign busStop = scl_i && core_q.sclQ && !core_q.sdaQ && sda_i;

	// Time base and counters.
	rra_divider u_divider (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.osc_i(osc_i),
		.taps(taps),
		.tick(secTick)
	);

	rra_calendar u_calendar (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(secTick),
		.freeze(core_q.busy),
		.wr(timeWr),
		.timeNow(timeNow)
	);

	// Counter writes leave one cycle after the byte is taken.
	assign timeWr = '{stb: core_q.wrStb && isTime(core_q.wrAddr),
		idx: 3'(core_q.wrAddr - rra_pkg::ADDR_SEC), data: core_q.wrData};

	// serial byte engine
	// Input bits are taken on the clock rise, our own data changes after the fall,
	// so the data line never moves while the clock is high.
	always_comb begin
		core_d = core_q;
		core_d.sclQ = scl_i;
		core_d.sdaQ = sda_i;
		core_d.wrStb = 1'b0;
		core_d.freqOut = clk_out_enable_in
			&& tapSel(core_q.regs[rra_pkg::ADDR_CTRL2][rra_pkg::FSEL_MSB:rra_pkg::FSEL_LSB], taps);
		if (busStop) begin
			core_d.st = rra_pkg::ST_IDLE;
			core_d.sdaOe = 1'b0;
			core_d.busy = 1'b0;
		end else if (busStart) begin
			core_d.st = rra_pkg::ST_ADDR;
			core_d.bits = 4'h0;
			core_d.sdaOe = 1'b0;
			core_d.busy = 1'b1;
		end else begin
			if (sclRise && (core_q.st == rra_pkg::ST_ADDR || core_q.st == rra_pkg::ST_PTR
				|| core_q.st == rra_pkg::ST_WDATA)) begin
				core_d.shift = {core_q.shift[6:0], sda_i};
				core_d.bits = core_q.bits + 4'h1;
			end
			case (core_q.st)
				rra_pkg::ST_IDLE: begin
					core_d.sdaOe = 1'b0;
				end
				rra_pkg::ST_ADDR: begin
					if (sclFall && core_q.bits == rra_pkg::BYTE_BITS) begin
						if (core_q.shift[7:1] == DEV_ADDR) begin
							core_d.sdaOe = 1'b1;
							core_d.rw = core_q.shift[0];
							core_d.st = rra_pkg::ST_ADDR_ACK;
						end else begin
							// Another device is addressed, so time keeps running.
							core_d.st = rra_pkg::ST_IDLE;
							core_d.busy = 1'b0;
						end
					end
				end
				rra_pkg::ST_ADDR_ACK: begin
					if (sclFall) begin
						if (core_q.rw) begin
							core_d = loadRead(core_d, timeNow);
						end else begin
							core_d.sdaOe = 1'b0;
							core_d.bits = 4'h0;
							core_d.st = rra_pkg::ST_PTR;
						end
					end
				end
				rra_pkg::ST_PTR: begin
					if (sclFall && core_q.bits == rra_pkg::BYTE_BITS) begin
						core_d.ptr = core_q.shift;
						core_d.sdaOe = 1'b1;
						core_d.st = rra_pkg::ST_PTR_ACK;
					end
				end
				rra_pkg::ST_PTR_ACK, rra_pkg::ST_WDATA_ACK: begin
					if (sclFall) begin
						core_d.sdaOe = 1'b0;
						core_d.bits = 4'h0;
						core_d.st = rra_pkg::ST_WDATA;
					end
				end
				rra_pkg::ST_WDATA: begin
					if (sclFall && core_q.bits == rra_pkg::BYTE_BITS) begin
						core_d.wrStb = 1'b1;
						core_d.wrAddr = core_q.ptr;
						core_d.wrData = core_q.shift;
						if (!isTime(core_q.ptr) && core_q.ptr <= rra_pkg::ADDR_LAST) begin
							core_d.regs[core_q.ptr[4:0]] = core_q.shift;
						end
						core_d.ptr = nextPtr(core_q.ptr);
						core_d.sdaOe = 1'b1;
						core_d.st = rra_pkg::ST_WDATA_ACK;
					end
				end
				rra_pkg::ST_RDATA: begin
					if (sclRise) begin
						core_d.bits = core_q.bits + 4'h1;
					end else if (sclFall) begin
						if (core_q.bits == rra_pkg::BYTE_BITS) begin
							core_d.sdaOe = 1'b0;
							core_d.st = rra_pkg::ST_HOST_ACK;
						end else begin
							core_d.shift = {core_q.shift[6:0], 1'b0};
							core_d.sdaOe = ~core_q.shift[6];
						end
					end
				end
				rra_pkg::ST_HOST_ACK: begin
					// A refused byte ends the read; the freeze lasts until the stop.
					if (sclRise && sda_i) begin
						core_d.st = rra_pkg::ST_IDLE;
					end else if (sclFall) begin
						core_d = loadRead(core_d, timeNow);
					end
				end
				default: begin
					core_d.st = rra_pkg::ST_IDLE;
					core_d.sdaOe = 1'b0;
				end
			endcase
		end
	end

	// State register; the lines idle high.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			core_q <= '0;
			core_q.st <= rra_pkg::ST_IDLE;
			core_q.sclQ <= 1'b1;
			core_q.sdaQ <= 1'b1;
		end else begin
			core_q <= core_d;
		end
	end

	// Open drain: the data line is only ever pulled low.
	assign sda_o = 1'b0;
	assign sda_oe = core_q.sdaOe;
	assign prog_freq_out = core_q.freqOut;

	chk_ptr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
		core_q.wrStb |-> (core_q.ptr == nextPtr(core_q.wrAddr)))
		else $error("Pointer did not step after a write.");
	chk_scratch_keep: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(core_q.wrStb && core_q.wrAddr == rra_pkg::ADDR_SCRATCH)
		|-> (core_q.regs[rra_pkg::ADDR_SCRATCH[4:0]] == core_q.wrData))
		else $error("Scratch byte lost its value.");
	chk_prog_freq_out_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!clk_out_enable_in |=> !prog_freq_out)
		else $error("Clock output toggled while disabled.");
	chk_stop_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		busStop |=> (!core_q.busy && !sda_oe))
		else $error("Freeze or drive held after stop.");
	chk_nack_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(core_q.st == rra_pkg::ST_HOST_ACK && sclRise && sda_i && !busStart && !busStop)
		|=> (core_q.st == rra_pkg::ST_IDLE && !sda_oe))
		else $error("Read went on after a refused byte.");
endmodule : rra_access_map

// >>> rra_pkg.sv
// Constants, register map and carrier types of the RTC register access core.
package rra_pkg;
	// Register map.
	localparam int REG_COUNT = 18;
	localparam logic [7:0] ADDR_CTRL1 = 8'h00;
	localparam logic [7:0] ADDR_CTRL2 = 8'h01;
	localparam logic [7:0] ADDR_TRIM = 8'h02;
	localparam logic [7:0] ADDR_SCRATCH = 8'h03;
	localparam logic [7:0] ADDR_SEC = 8'h04;
	localparam logic [7:0] ADDR_YEAR = 8'h0a;
	localparam logic [7:0] ADDR_ALARM_FIRST = 8'h0b;
	localparam logic [7:0] ADDR_ALARM_LAST = 8'h0f;
	localparam logic [7:0] ADDR_TIMER_VALUE = 8'h10;
	localparam logic [7:0] ADDR_TIMER_MODE = 8'h11;
	localparam logic [7:0] ADDR_FIRST = 8'h00;
	localparam logic [7:0] ADDR_LAST = 8'h11;
	localparam logic [7:0] REG_RESET = 8'h00;
	// Clock-out select field in the second control register.
	localparam int FSEL_LSB = 0;
	localparam int FSEL_MSB = 2;
	localparam logic [2:0] FSEL_32K = 3'h0;
	localparam logic [2:0] FSEL_1K = 3'h5;
	localparam logic [2:0] FSEL_1HZ = 3'h6;
	// Time base: the divider is as wide as the oscillator rate is a power of two.
	localparam int OSC_HZ = 32768;
	localparam int DIV_BITS = 15;
	localparam logic [DIV_BITS-1:0] DIV_LAST = 15'h7fff;
	// Bus timing against the system clock.
	localparam int CLK_HZ = 40000000;
	localparam int BUS_MAX_BPS = 400000;
	localparam int OVERSAMPLE_MIN = 8;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	localparam logic [6:0] DEF_DEV_ADDR = 7'h52;
	// BCD limits of the counters.
	localparam logic [7:0] SEC_MAX = 8'h59;
	localparam logic [7:0] MIN_MAX = 8'h59;
	localparam logic [7:0] HOUR_MAX = 8'h23;
	localparam logic [7:0] WDAY_MAX = 8'h06;
	localparam logic [7:0] MON_MAX = 8'h12;
	localparam logic [7:0] YEAR_MAX = 8'h99;
	localparam logic [7:0] BCD_ZERO = 8'h00;
	localparam logic [7:0] BCD_ONE = 8'h01;
	// Counter bytes in address order, seconds in the top byte.
	typedef struct packed {
		logic [7:0] sec;
		logic [7:0] min;
		logic [7:0] hour;
		logic [7:0] day;
		logic [7:0] wday;
		logic [7:0] mon;
		logic [7:0] year;
	} rra_time_t;
	localparam rra_time_t TIME_RESET = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00};
	// Divider taps: raw oscillator level and the ripple stages.
	typedef struct packed {
		logic osc;
		logic [DIV_BITS-1:0] cnt;
	} rra_taps_t;
	// Write of one counter byte, index 0 is seconds.
	typedef struct packed {
		logic stb;
		logic [2:0] idx;
		logic [7:0] data;
	} rra_wr_t;
	// Bus engine states.
	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_ADDR_ACK = 9'h004,
		ST_PTR = 9'h008,
		ST_PTR_ACK = 9'h010,
		ST_WDATA = 9'h020,
		ST_WDATA_ACK = 9'h040,
		ST_RDATA = 9'h080,
		ST_HOST_ACK = 9'h100
	} rra_bus_st_t;
endpackage : rra_pkg

// >>> rra_divider.sv
// Divider chain that turns the oscillator into clock-out taps and a one-second tick.
`timescale 1ns/1ps
module rra_divider (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Oscillator level.
	input wire logic osc_i,
	// Taps and tick.
	output rra_pkg::rra_taps_t taps,
	output logic tick
);
	typedef struct packed {
		logic oscQ;
		logic [rra_pkg::DIV_BITS-1:0] cnt;
		logic tick;
	} rra_div_t;
	rra_div_t div_q;
	rra_div_t div_d;

	// divider chain
	// Each oscillator rising edge steps the chain; the wrap marks one second.
	always_comb begin
		div_d = div_q;
		div_d.oscQ = osc_i;
		div_d.tick = 1'b0;
		if (osc_i && !div_q.oscQ) begin
			div_d.cnt = div_q.cnt + 1'b1;
			div_d.tick = (div_q.cnt == rra_pkg::DIV_LAST);
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_d;
		end
	end

	assign taps = '{osc: div_q.oscQ, cnt: div_q.cnt};
	assign tick = div_q.tick;

	chk_tick_wrap: assert property (@(posedge clk_sys) disable iff (!rst_n) tick |-> (div_q.cnt == '0))
		else $error("Second tick without divider wrap.");
endmodule : rra_divider

// >>> rra_calendar.sv
// BCD clock and calendar counters with access freeze and deferred second.
`timescale 1ns/1ps
module rra_calendar (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Time base and access control.
	input wire logic tick,
	input wire logic freeze,
	input rra_pkg::rra_wr_t wr,
	// Current counters.
	output rra_pkg::rra_time_t timeNow
);
	typedef struct packed {
		rra_pkg::rra_time_t t;
		logic pend;
	} rra_cal_t;
	localparam rra_cal_t CAL_RESET = '{t: rra_pkg::TIME_RESET, pend: 1'b0};
	rra_cal_t cal_q;
	rra_cal_t cal_d;

	// BCD increment with wrap; the top bit is the carry.
	function automatic logic [8:0] bcdInc(input logic [7:0] v, input logic [7:0] hi, input logic [7:0] lo);
		if (v >= hi) begin
			return {1'b1, lo};
		end
		if (v[3:0] == 4'h9) begin
			return {1'b0, v[7:4] + 4'h1, 4'h0};
		end
		return {1'b0, v + 8'h01};
	endfunction : bcdInc

	// Last BCD day of a month; years divisible by four are leap years.
	function automatic logic [7:0] monthLast(input logic [7:0] mon, input logic [7:0] year);
		logic [1:0] rem;
		rem = {year[4], 1'b0} + year[1:0];
		case (mon)
			8'h02: return (rem == 2'h0) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction : monthLast

	// A tick during a freeze is parked and applied once the freeze ends.
	always_comb begin
		logic [8:0] r;
		r = 9'h000;
		cal_d = cal_q;
		if (freeze) begin
			if (tick) begin
				cal_d.pend = 1'b1;
			end
		end else if (tick || cal_q.pend) begin
			cal_d.pend = tick && cal_q.pend;
			r = bcdInc({1'b0, cal_q.t.sec[6:0]}, rra_pkg::SEC_MAX, rra_pkg::BCD_ZERO);
			cal_d.t.sec = {cal_q.t.sec[7], r[6:0]};
			if (r[8]) begin
				r = bcdInc(cal_q.t.min, rra_pkg::MIN_MAX, rra_pkg::BCD_ZERO);
				cal_d.t.min = r[7:0];
				if (r[8]) begin
					r = bcdInc(cal_q.t.hour, rra_pkg::HOUR_MAX, rra_pkg::BCD_ZERO);
					cal_d.t.hour = r[7:0];
					if (r[8]) begin
						r = bcdInc(cal_q.t.wday, rra_pkg::WDAY_MAX, rra_pkg::BCD_ZERO);
						cal_d.t.wday = r[7:0];
						r = bcdInc(cal_q.t.day, monthLast(cal_q.t.mon, cal_q.t.year), rra_pkg::BCD_ONE);
						cal_d.t.day = r[7:0];
						if (r[8]) begin
							r = bcdInc(cal_q.t.mon, rra_pkg::MON_MAX, rra_pkg::BCD_ONE);
							cal_d.t.mon = r[7:0];
							if (r[8]) begin
								r = bcdInc(cal_q.t.year, rra_pkg::YEAR_MAX, rra_pkg::BCD_ZERO);
								cal_d.t.year = r[7:0];
							end
						end
					end
				end
			end
		end
		if (wr.stb) begin
			case (wr.idx)
				3'h0: cal_d.t.sec = wr.data;
				3'h1: cal_d.t.min = wr.data;
				3'h2: cal_d.t.hour = wr.data;
				3'h3: cal_d.t.day = wr.data;
				3'h4: cal_d.t.wday = wr.data;
				3'h5: cal_d.t.mon = wr.data;
				3'h6: cal_d.t.year = wr.data;
				default: cal_d.t = cal_q.t;
			endcase
		end
	end

	// State register.
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cal_q <= CAL_RESET;
		end else begin
			cal_q <= cal_d;
		end
	end

	assign timeNow = cal_q.t;

	chk_freeze_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(freeze && !wr.stb) |=> (cal_q.t == $past(cal_q.t)))
		else $error("Counters moved during a freeze.");
	chk_pend_apply: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cal_q.pend && !freeze && !wr.stb) |=> (cal_q.t.sec != $past(cal_q.t.sec)))
		else $error("Parked second not applied.");
	chk_bcd_roll: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(!freeze && (tick || cal_q.pend) && !wr.stb && cal_q.t.sec[3:0] == 4'h9) |=> (cal_q.t.sec[3:0] == 4'h0))
		else $error("Seconds digit left BCD.");
endmodule : rra_calendar

// >>> rra_host_model.sv
// Behavioural two-wire bus controller that drives the RTC core from the host side.
`timescale 1ns/1ps
module rra_host_model (
	// Clock.
	input wire logic clk_sys,
	// Bus wires; the data wire is resolved by the bench.
	input wire logic sdaWire,
	output logic sclLine,
	output logic sdaLow
);
	// Fifty cycles a half bit gives 100 cycles a bit, 400 kbit/s at 40 MHz.
	localparam int HALF = 50;

	// Both lines idle high from time zero.
	initial begin
		sclLine = 1'b1;
		sdaLow = 1'b0;
	end

	task automatic half;
		repeat (HALF) @(posedge clk_sys);
	endtask : half

	// Start or repeated start; the clock is left low.
	task automatic startBit;
		sdaLow <= 1'b0;
		half();
		sclLine <= 1'b1;
		half();
		sdaLow <= 1'b1;
		half();
		sclLine <= 1'b0;
		half();
	endtask : startBit

	// Stop; both lines end released.
	task automatic stopBit;
		sdaLow <= 1'b1;
		half();
		sclLine <= 1'b1;
		half();
		sdaLow <= 1'b0;
		half();
	endtask : stopBit

	// One bit; the extra edge keeps the data change clear of the clock fall.
	task automatic bitIo(input logic b, output logic got);
		sdaLow <= ~b;
		half();
		sclLine <= 1'b1;
		half();
		got = sdaWire;
		sclLine <= 1'b0;
		@(posedge clk_sys);
	endtask : bitIo

	// Byte out, most significant bit first, then the device's acknowledge.
	task automatic sendByte(input logic [7:0] d, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bitIo(d[i], g);
		end
		bitIo(1'b1, g);
		ack = ~g;
	endtask : sendByte

	// Byte in; the last byte of a read is refused with a high acknowledge bit.
	task automatic getByte(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--) begin
			bitIo(1'b1, g);
			d[i] = g;
		end
		bitIo(last, g);
	endtask : getByte
endmodule : rra_host_model

// >>> rra_access_map_bench.sv
// Self-checking bench of the RTC register access core.
`timescale 1ns/1ps
module rra_access_map_bench;
	localparam logic [7:0] ADDR_WR = 8'ha4;
	localparam logic [7:0] ADDR_RD = 8'ha5;
	localparam int WIN = 640;
	typedef struct packed {
		logic [2:0] sel;
		logic en;
		logic [15:0] rises;
	} rra_row_t;
	logic clk_sys;
	logic rst_n;
	logic osc_i = 1'b0;
	logic clk_out_enable_in;
	logic sclLine;
	logic sdaLow;
	logic sda_o;
	logic sda_oe;
	logic prog_freq_out;
	logic sdaWire;
	logic [7:0] rdByte;
	int bad_count;
	int checks;
	int cyc = 0;
	int relCyc;
	// Oscillator toggles every cycle: tap 0 has a period of 2 cycles, tap 1 of 4, tap 5 of 64.
	rra_row_t rows [5] = '{'{rra_pkg::FSEL_32K, 1'b1, 16'h0140}, '{3'h1, 1'b1, 16'h00a0},
		'{rra_pkg::FSEL_1K, 1'b1, 16'h000a},
		'{3'h7, 1'b1, 16'h0000}, '{rra_pkg::FSEL_32K, 1'b0, 16'h0000}};

	// Data wire has a pull-up; either party may pull it low.
	assign sdaWire = ~(sdaLow | (sda_oe & ~sda_o));

	rra_access_map #(.DEV_ADDR(7'h52)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .scl_i(sclLine),
		.sda_i(sdaWire), .sda_o(sda_o), .sda_oe(sda_oe), .osc_i(osc_i),
		.clk_out_enable_in(clk_out_enable_in), .prog_freq_out(prog_freq_out));
	rra_host_model host_u (.clk_sys(clk_sys), .sdaWire(sdaWire), .sclLine(sclLine), .sdaLow(sdaLow));

	// System clock of 25 ns.
	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// Fast oscillator so one second passes in 65536 cycles; cycle counter beside it.
	always @(posedge clk_sys) begin
		osc_i <= ~osc_i;
		cyc <= cyc + 1;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, want);
		end
	endtask : check

	task automatic stop_test;
		if (bad_count == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	task automatic txByte(input logic [7:0] d, input logic ackWant);
		logic a;
		host_u.sendByte(d, a);
		check({15'h0000, a}, {15'h0000, ackWant});
	endtask : txByte

	// Burst write from a pointer.
	task automatic writeRegs(input logic [7:0] ptr, input logic [7:0] dat[$]);
		host_u.startBit();
		txByte(ADDR_WR, 1'b1);
		txByte(ptr, 1'b1);
		foreach (dat[i]) begin
			txByte(dat[i], 1'b1);
		end
		host_u.stopBit();
	endtask : writeRegs

	// Pointer set, repeated start, then a burst read compared byte by byte.
	task automatic readRegs(input logic [7:0] ptr, input logic [7:0] wantQ[$]);
		logic [7:0] d;
		host_u.startBit();
		txByte(ADDR_WR, 1'b1);
		txByte(ptr, 1'b1);
		host_u.startBit();
		txByte(ADDR_RD, 1'b1);
		foreach (wantQ[i]) begin
			host_u.getByte(i == wantQ.size() - 1, d);
			check({8'h00, d}, {8'h00, wantQ[i]});
		end
		host_u.stopBit();
	endtask : readRegs

	// Hang guard: the whole sequence needs about 94000 cycles.
	initial begin
		repeat (100000) @(posedge clk_sys);
		bad_count++;
		stop_test();
	end

	initial begin
		int n;
		logic prev;
		logic [15:0] seen;
		rst_n = 1'b0;
		clk_out_enable_in = 1'b0;
		bad_count = 0;
		checks = 0;
		repeat (6) @(posedge clk_sys);
		// Outputs are quiet while reset is held.
		check({13'h0000, sda_o, sda_oe, prog_freq_out}, 16'h0000);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk_sys);
		// Clock output select and enable, counting rises over a fixed window.
		foreach (rows[i]) begin
			writeRegs(rra_pkg::ADDR_CTRL2, '{{5'h00, rows[i].sel}});
			clk_out_enable_in <= rows[i].en;
			repeat (4) @(posedge clk_sys);
			n = 0;
			prev = prog_freq_out;
			for (int k = 0; k < WIN; k++) begin
				@(posedge clk_sys);
				if (prog_freq_out === 1'b1 && prev === 1'b0) n++;
				prev = prog_freq_out;
			end
			// A window may cut one rise at either end, so one count either way is accepted where rises are expected; a zero row must count none.
			seen = (rows[i].rises != 0 && n + 1 >= rows[i].rises && n <= rows[i].rises + 1) ? rows[i].rises : 16'(n);
			check(seen, rows[i].rises);
		end
		// Reset again in mid run; the divider restarts with it.
		rst_n <= 1'b0;
		repeat (6) @(posedge clk_sys);
		check({13'h0000, sda_o, sda_oe, prog_freq_out}, 16'h0000);
		rst_n <= 1'b1;
		relCyc = cyc;
		repeat (2) @(posedge clk_sys);
		readRegs(8'h00, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h01, 8'h00});
		// Burst across the top of the map lands in 10h, 11h, then 00h to 03h.
		writeRegs(rra_pkg::ADDR_TIMER_VALUE, '{8'ha1, 8'h3c, 8'h5a, 8'h07, 8'h96, 8'hc3});
		readRegs(rra_pkg::ADDR_ALARM_LAST, '{8'h00, 8'ha1, 8'h3c, 8'h5a, 8'h07, 8'h96, 8'hc3});
		// A foreign address is not acknowledged.
		host_u.startBit();
		txByte(8'ha6, 1'b0);
		host_u.stopBit();
		// Seconds one short of a carry, in BCD.
		writeRegs(rra_pkg::ADDR_SEC, '{8'h59, 8'h00});
		// Hold a transaction open across the second tick; counters must not move.
		host_u.startBit();
		txByte(ADDR_WR, 1'b1);
		wait (cyc >= relCyc + 67000);
		txByte(rra_pkg::ADDR_SEC, 1'b1);
		host_u.startBit();
		txByte(ADDR_RD, 1'b1);
		host_u.getByte(1'b1, rdByte);
		check({8'h00, rdByte}, 16'h0059);
		host_u.stopBit();
		// The parked second is applied after the stop, carrying into minutes.
		readRegs(rra_pkg::ADDR_SEC, '{8'h00, 8'h01});
		stop_test();
	end
endmodule : rra_access_map_bench
